// [inc/bsdp_params.svh]
// constants of the boundary-scan test data path
// assumes inclusion by bsdp_pkg, bsdp_top and the testbench files; definitions only
`ifndef BSDP_PARAMS_SVH
`define BSDP_PARAMS_SVH

`define BSDP_IR_LEN      5
`define BSDP_PIN_N       8
`define BSDP_BSR_LEN     9
`define BSDP_CTL_CELL    8
`define BSDP_OP_EXTEST   5'h00
`define BSDP_OP_SAMPLE   5'h01
`define BSDP_OP_BYPASS   5'h1f
`define BSDP_IR_CAPTURE  5'h0d
`define BSDP_IR_RESET    5'h1f
`define BSDP_FIFO_DEPTH  8
`define BSDP_CLK_NS      40
`define BSDP_TCK_MIN_NS  100
`define BSDP_TCK_MIN_CYC ((`BSDP_TCK_MIN_NS + `BSDP_CLK_NS - 1) / `BSDP_CLK_NS)

`endif

// [inc/bsdp_pkg.sv]
// types shared by the boundary-scan data path files
// assumes bsdp_params.svh on the include path
`include "bsdp_params.svh"

package bsdp_pkg;

    typedef enum logic [3:0] {
        BSDP_TLR    = 4'b1111,
        BSDP_RTI    = 4'b1100,
        BSDP_SEL_DR = 4'b0111,
        BSDP_CAP_DR = 4'b0110,
        BSDP_SH_DR  = 4'b0010,
        BSDP_EX1_DR = 4'b0001,
        BSDP_PA_DR  = 4'b0011,
        BSDP_EX2_DR = 4'b0000,
        BSDP_UPD_DR = 4'b0101,
        BSDP_SEL_IR = 4'b0100,
        BSDP_CAP_IR = 4'b1110,
        BSDP_SH_IR  = 4'b1010,
        BSDP_EX1_IR = 4'b1001,
        BSDP_PA_IR  = 4'b1011,
        BSDP_EX2_IR = 4'b1000,
        BSDP_UPD_IR = 4'b1101
    } bsdp_tap_t;

    // one group of pad drive signals
    typedef struct packed {
        logic [`BSDP_PIN_N-1:0] val;
        logic [`BSDP_PIN_N-1:0] oe;
    } bsdp_pad_t;

    typedef logic [`BSDP_BSR_LEN-1:0] bsdp_bsr_t;

endpackage : bsdp_pkg

// [rtl/bsdp_fifo.sv]
// snapshot fifo with a registered read stage
// assumes one clock domain, asynchronous active-low reset
`timescale 1ns/1ps

module bsdp_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    // ------------------------------------------------------------
    // flow control
    // ------------------------------------------------------------
    assign push = in_valid && in_ready;
    assign pop  = (cnt_r != '0) && (!out_valid || out_ready);

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r    <= '0;
            in_ready <= 1'b1;
        end else begin
            cnt_r    <= cnt_nxt;
            in_ready <= (cnt_nxt != DEPTH[AW:0]);
        end
    end

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    // read stage: data leave from a register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rp_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule : bsdp_fifo

// [rtl/bsdp_top.sv]
// boundary-scan test data path: tap sequencer, ir, bypass, boundary cells
// assumes tck, tms, tdi, ntrst and pad levels arrive asynchronous to clk;
// clk must run well above twice the tck rate
`timescale 1ns/1ps
`include "bsdp_params.svh"

module bsdp_top
    import bsdp_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   tck,
    input  wire logic                   tms,
    input  wire logic                   tdi,
    input  wire logic                   ntrst,
    output logic                        tdo,
    output logic                        tdo_oe,
    input  wire logic [`BSDP_PIN_N-1:0] pad_in,
    output logic [`BSDP_PIN_N-1:0]      pad_out,
    output logic [`BSDP_PIN_N-1:0]      pad_oe,
    input  wire logic [`BSDP_PIN_N-1:0] core_out,
    input  wire logic                   core_oe,
    output logic [`BSDP_PIN_N-1:0]      core_in,
    output logic [`BSDP_BSR_LEN-1:0]    snap_data,
    output logic                        snap_valid,
    input  wire logic                   snap_ready,
    output logic                        snap_space
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]              tck_sy_r;
    logic [1:0]              tms_sy_r;
    logic [1:0]              tdi_sy_r;
    logic [1:0]              trst_sy_r;
    logic [`BSDP_PIN_N-1:0]  pad_sy1_r;
    logic [`BSDP_PIN_N-1:0]  pad_sy2_r;
    logic                    tck_rise;
    logic                    tck_fall;
    logic                    tms_s;
    logic                    tdi_s;
    logic                    trst_n_s;
    bsdp_tap_t               tap_r;
    bsdp_tap_t               tap_nxt;
    logic [`BSDP_IR_LEN-1:0] ir_sh_r;
    logic [`BSDP_IR_LEN-1:0] ir_act_r;
    logic                    byp_r;
    bsdp_bsr_t               bsr_sh_r;
    bsdp_bsr_t               bsr_up_r;
    bsdp_bsr_t               bsr_cap;
    logic                    sel_extest;
    logic                    sel_sample;
    logic                    sel_bsr;
    logic                    ser_bit;
    logic                    shift_st;
    logic                    ctl_cell;
    logic                    snap_push;
    logic                    fifo_in_ready;
    bsdp_pad_t               pad_drv;

    // ------------------------------------------------------------
    // synchronisers and tck edge finding
    // ------------------------------------------------------------
    // stage one of each chain feeds stage two only; edges come from later stages
    // each tck phase must span more than one clk cycle or its edge is lost
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tck_sy_r  <= 3'h0;
            tms_sy_r  <= 2'h3;
            tdi_sy_r  <= 2'h3;
            trst_sy_r <= 2'h0;
        end else begin
            tck_sy_r  <= {tck_sy_r[1:0], tck};
            tms_sy_r  <= {tms_sy_r[0], tms};
            tdi_sy_r  <= {tdi_sy_r[0], tdi};
            trst_sy_r <= {trst_sy_r[0], ntrst};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pad_sy1_r <= '0;
            pad_sy2_r <= '0;
        end else begin
            pad_sy1_r <= pad_in;
            pad_sy2_r <= pad_sy1_r;
        end
    end

    // tms and tdi sampled with the same two-stage lag as the tck edge
    assign tck_rise = tck_sy_r[1] && !tck_sy_r[2];
    assign tck_fall = !tck_sy_r[1] && tck_sy_r[2];
    assign tms_s    = tms_sy_r[1];
    assign tdi_s    = tdi_sy_r[1];
    assign trst_n_s = trst_sy_r[1];

    // ------------------------------------------------------------
    // tap state machine
    // ------------------------------------------------------------
    // five tms-high rises reach reset from any state; no extra counter needed
    always_comb begin
        case (tap_r)
            BSDP_TLR:    tap_nxt = tms_s ? BSDP_TLR    : BSDP_RTI;
            BSDP_RTI:    tap_nxt = tms_s ? BSDP_SEL_DR : BSDP_RTI;
            BSDP_SEL_DR: tap_nxt = tms_s ? BSDP_SEL_IR : BSDP_CAP_DR;
            BSDP_CAP_DR: tap_nxt = tms_s ? BSDP_EX1_DR : BSDP_SH_DR;
            BSDP_SH_DR:  tap_nxt = tms_s ? BSDP_EX1_DR : BSDP_SH_DR;
            BSDP_EX1_DR: tap_nxt = tms_s ? BSDP_UPD_DR : BSDP_PA_DR;
            BSDP_PA_DR:  tap_nxt = tms_s ? BSDP_EX2_DR : BSDP_PA_DR;
            BSDP_EX2_DR: tap_nxt = tms_s ? BSDP_UPD_DR : BSDP_SH_DR;
            BSDP_UPD_DR: tap_nxt = tms_s ? BSDP_SEL_DR : BSDP_RTI;
            BSDP_SEL_IR: tap_nxt = tms_s ? BSDP_TLR    : BSDP_CAP_IR;
            BSDP_CAP_IR: tap_nxt = tms_s ? BSDP_EX1_IR : BSDP_SH_IR;
            BSDP_SH_IR:  tap_nxt = tms_s ? BSDP_EX1_IR : BSDP_SH_IR;
            BSDP_EX1_IR: tap_nxt = tms_s ? BSDP_UPD_IR : BSDP_PA_IR;
            BSDP_PA_IR:  tap_nxt = tms_s ? BSDP_EX2_IR : BSDP_PA_IR;
            BSDP_EX2_IR: tap_nxt = tms_s ? BSDP_UPD_IR : BSDP_SH_IR;
            BSDP_UPD_IR: tap_nxt = tms_s ? BSDP_SEL_DR : BSDP_RTI;
            default:     tap_nxt = BSDP_TLR;
        endcase
    end

    // synchronised test reset wins over any tck edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tap_r <= BSDP_TLR;
        end else if (!trst_n_s) begin
            tap_r <= BSDP_TLR;
        end else if (tck_rise) begin
            tap_r <= tap_nxt;
        end
    end

    // ------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir_sh_r <= `BSDP_IR_CAPTURE;
        end else if (tck_rise) begin
            if (tap_r == BSDP_CAP_IR) begin
                ir_sh_r <= `BSDP_IR_CAPTURE;
            end else if (tap_r == BSDP_SH_IR) begin
                ir_sh_r <= {tdi_s, ir_sh_r[`BSDP_IR_LEN-1:1]};
            end
        end
    end

    // output stage: a new opcode acts only after the update fall
    // it returns to bypass whenever the tap sits in reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir_act_r <= `BSDP_IR_RESET;
        end else if (tap_r == BSDP_TLR) begin
            ir_act_r <= `BSDP_IR_RESET;
        end else if (tck_fall && tap_r == BSDP_UPD_IR) begin
            ir_act_r <= ir_sh_r;
        end
    end

    // unknown opcodes fall back to bypass
    assign sel_extest = (ir_act_r == `BSDP_OP_EXTEST);
    assign sel_sample = (ir_act_r == `BSDP_OP_SAMPLE);
    assign sel_bsr    = sel_extest || sel_sample;

    // ------------------------------------------------------------
    // bypass register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byp_r <= 1'b0;
        end else if (tck_rise && !sel_bsr) begin
            if (tap_r == BSDP_CAP_DR) begin
                byp_r <= 1'b0;
            end else if (tap_r == BSDP_SH_DR) begin
                byp_r <= tdi_s;
            end
        end
    end

    // ------------------------------------------------------------
    // boundary register: master stage
    // ------------------------------------------------------------
    // pin cells see the pad level; the control cell sees the core enable
    assign bsr_cap = {core_oe, pad_sy2_r};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bsr_sh_r <= '0;
        end else if (tck_rise && sel_bsr) begin
            if (tap_r == BSDP_CAP_DR) begin
                bsr_sh_r <= bsr_cap;
            end else if (tap_r == BSDP_SH_DR) begin
                bsr_sh_r <= {tdi_s, bsr_sh_r[`BSDP_BSR_LEN-1:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // boundary register: slave stage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bsr_up_r <= '0;
        end else if (tck_fall && tap_r == BSDP_UPD_DR && sel_bsr) begin
            bsr_up_r <= bsr_sh_r;
        end
    end

    // ------------------------------------------------------------
    // pad and core muxing, one slice per pin
    // ------------------------------------------------------------
    // one control cell governs every pin of the group
    assign ctl_cell = bsr_up_r[`BSDP_CTL_CELL];

    // outside extest the cells are bypassed entirely by the functional path
    genvar gi;
    generate
        for (gi = 0; gi < `BSDP_PIN_N; gi = gi + 1) begin : g_pin
            always_comb begin
                if (sel_extest) begin
                    pad_drv.val[gi] = bsr_up_r[gi];
                    pad_drv.oe[gi]  = ctl_cell;
                end else begin
                    pad_drv.val[gi] = core_out[gi];
                    pad_drv.oe[gi]  = core_oe;
                end
            end
        end
    endgenerate

    // pads follow the slave cells one clk after an update
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pad_out <= '0;
            pad_oe  <= '0;
        end else begin
            pad_out <= pad_drv.val;
            pad_oe  <= pad_drv.oe;
        end
    end

    // in extest the core is fed from the slave cells, not the pads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_in <= '0;
        end else if (sel_extest) begin
            core_in <= bsr_up_r[`BSDP_PIN_N-1:0];
        end else begin
            core_in <= pad_sy2_r;
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    always_comb begin
        if (tap_r == BSDP_SH_IR) begin
            ser_bit = ir_sh_r[0];
        end else if (sel_bsr) begin
            ser_bit = bsr_sh_r[0];
        end else begin
            ser_bit = byp_r;
        end
    end

    // shift states are the only ones that drive the pin
    assign shift_st = (tap_r == BSDP_SH_IR) || (tap_r == BSDP_SH_DR);

    // tdo changes only on the tck fall, half a period before it is sampled;
    // outside the shift states it keeps its last bit so the floating pin stays quiet
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tdo <= 1'b0;
        end else if (tck_fall && shift_st) begin
            tdo <= ser_bit;
        end
    end

    // the enable drops at once under test reset, not at the next fall
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tdo_oe <= 1'b0;
        end else if (!trst_n_s) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= shift_st;
        end
    end

    // ------------------------------------------------------------
    // capture snapshot buffer
    // ------------------------------------------------------------
    // a capture seen while the buffer is full is not queued; snap_space warns
    // the scan never waits on the consumer, so overflow drops the newest word
    assign snap_push = tck_rise && sel_bsr && (tap_r == BSDP_CAP_DR);

    bsdp_fifo #(
        .W     (`BSDP_BSR_LEN),
        .DEPTH (`BSDP_FIFO_DEPTH)
    ) u_snap (
        .clk       (clk),
        .nrst      (nrst),
        .in_data   (bsr_cap),
        .in_valid  (snap_push),
        .in_ready  (fifo_in_ready),
        .out_data  (snap_data),
        .out_valid (snap_valid),
        .out_ready (snap_ready)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            snap_space <= 1'b1;
        end else begin
            snap_space <= fifo_in_ready;
        end
    end

endmodule : bsdp_top

// [testbench/bsdp_master.sv]
// behavioural test master driving the tap pins
// assumes tdo settles within three quarters of the tck low phase
`timescale 1ns/1ps

module bsdp_master (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      ntrst,
    input  wire logic tdo
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
        ntrst = 1'h1;
    end

    // one 320 ns period; tck stands low between calls
    task automatic bit_io(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #160;
        q = tdo;
        tck = 1'h1;
        #160; // tms and tdi held all of the high phase for the sampler's lag
        tck = 1'h0;
    endtask : bit_io

    // from run-test-idle through one register and back
    task automatic scan(input logic ir, input int n, input logic [8:0] din,
                        output logic [8:0] dout);
        logic q;
        dout = 9'h0;
        bit_io(1'h1, 1'h0, q);
        if (ir)
            bit_io(1'h1, 1'h0, q);
        bit_io(1'h0, 1'h0, q);
        bit_io(1'h0, 1'h0, q);
        for (int i = 0; i < n; i++) begin
            bit_io(i == n - 1, din[i], q);
            dout[i] = q;
        end
        bit_io(1'h1, 1'h0, q);
        bit_io(1'h0, 1'h0, q);
    endtask : scan

    task automatic tms_reset();
        logic q;
        for (int i = 0; i < 5; i++)
            bit_io(1'h1, 1'h0, q);
        bit_io(1'h0, 1'h0, q);
    endtask : tms_reset

    task automatic trst_pulse();
        ntrst = 1'h0;
        #400;
        ntrst = 1'h1;
    endtask : trst_pulse
endmodule : bsdp_master

// [testbench/bsdp_top_properties.sv]
// checker for the boundary-scan data path, bound to bsdp_top
// assumes tck half periods of at least four clk cycles
`timescale 1ns/1ps
`include "bsdp_params.svh"

module bsdp_top_properties
    import bsdp_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     nrst,
    input wire logic                     tck,
    input wire logic                     ntrst,
    input wire logic                     tdo,
    input wire logic                     tdo_oe,
    input wire logic [`BSDP_PIN_N-1:0]   pad_out,
    input wire logic [`BSDP_PIN_N-1:0]   pad_oe,
    input wire logic [`BSDP_PIN_N-1:0]   core_out,
    input wire logic                     core_oe,
    input wire logic [`BSDP_BSR_LEN-1:0] snap_data,
    input wire logic                     snap_valid,
    input wire logic                     snap_ready,
    input wire logic                     snap_space
);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_tdo_after_fall: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
        else $error("tdo moved outside the tck low phase");
    a_oe_tck_high: assert property (tck |-> $stable(tdo_oe))
        else $error("tdo_oe moved while tck high");
    a_tdo_idle_hold: assert property (!tdo_oe && !$past(tdo_oe) |-> $stable(tdo))
        else $error("tdo moved while not driven");
    a_trst_floats: assert property (!ntrst [*5] |-> !tdo_oe)
        else $error("tdo_oe high under test reset");
    a_trst_bypass: assert property (!ntrst [*6] |->
        pad_out == $past(core_out) && pad_oe == {8{$past(core_oe)}})
        else $error("pads not functional under test reset");
    a_one_ctl_cell: assert property (pad_oe == {8{pad_oe[0]}})
        else $error("pad enables disagree");
    a_snap_hold: assert property (snap_valid && !snap_ready |=>
        snap_valid && $stable(snap_data))
        else $error("snapshot dropped while stalled");
    a_empty_room: assert property (!snap_valid && $past(!snap_valid) |-> snap_space)
        else $error("no room shown while empty");

    c_shift_end: cover property (tdo_oe ##1 !tdo_oe);
    c_snap_take: cover property (snap_valid && snap_ready);
    c_snap_full: cover property (!snap_space);
    c_pads_driven: cover property (pad_oe == 8'hff && !core_oe);
endmodule : bsdp_top_properties

bind bsdp_top bsdp_top_properties u_props (
    .clk(clk), .nrst(nrst), .tck(tck), .ntrst(ntrst), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad_out(pad_out), .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe),
    .snap_data(snap_data), .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_space(snap_space)
);

// [testbench/test_bsdp_top.sv]
// self-checking bench for bsdp_top with a behavioural test master
// assumes bsdp_master on the tap pins and the bound checker
`timescale 1ns/1ps
`include "bsdp_params.svh"

module test_bsdp_top
    import bsdp_pkg::*;
;
    logic                   clk;
    logic                   nrst;
    wire                    tck, tms, tdi, ntrst;
    logic                   tdo, tdo_oe, core_oe, snap_valid, snap_ready, snap_space, q;
    logic [`BSDP_PIN_N-1:0] pad_in, pad_out, pad_oe, core_out, core_in;
    bsdp_bsr_t              snap_data, dout;
    int                     errors, num_checks;

    bsdp_top uut (.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .ntrst(ntrst),
        .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .snap_data(snap_data),
        .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_space(snap_space));
    bsdp_master master (.tck(tck), .tms(tms), .tdi(tdi), .ntrst(ntrst), .tdo(tdo));

    always #20 clk = ~clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic pins(input logic [7:0] p, input logic [7:0] c, input logic oe,
                        input logic rdy);
        @(posedge clk);
        #1;
        pad_in = p;
        core_out = c;
        core_oe = oe;
        snap_ready = rdy;
        repeat (4) @(posedge clk);
        #1;
    endtask : pins

    task automatic load_ir(input logic [4:0] op);
        bsdp_bsr_t cap;
        master.scan(1'h1, 5, {4'h0, op}, cap);
        check("ir capture", cap, {4'h0, `BSDP_IR_CAPTURE});
    endtask : load_ir

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("tdo_oe", tdo_oe, 9'h0);
        check("pad_out", pad_out, core_out);
        check("snap_space", snap_space, 9'h1);
        master.tms_reset();
    endtask : t_reset

    task automatic t_bypass();
        logic [4:0] ops [2] = '{`BSDP_OP_BYPASS, 5'h0a};
        foreach (ops[i]) begin
            load_ir(ops[i]);
            master.scan(1'h0, 9, 9'h1a5, dout);
            check("bypass out", dout, 9'h14a);
            check("tdo_oe idle", tdo_oe, 9'h0);
        end
    endtask : t_bypass

    task automatic t_sample();
        pins(8'h96, 8'hc3, 1'h1, 1'h1);
        load_ir(`BSDP_OP_SAMPLE);
        master.scan(1'h0, 9, 9'h13c, dout);
        check("sample capture", dout, 9'h196);
        check("sample pad_out", pad_out, core_out);
        check("sample pad_oe", pad_oe, 9'hff);
    endtask : t_sample

    task automatic t_extest();
        load_ir(`BSDP_OP_EXTEST);
        check("ext pad_out", pad_out, 9'h3c);
        check("ext pad_oe", pad_oe, 9'hff);
        check("ext core_in", core_in, 9'h3c);
        master.scan(1'h0, 9, 9'h0a5, dout);
        check("ext capture", dout, 9'h196);
        check("ext pad_out 2", pad_out, 9'ha5);
        check("ext pad_oe 2", pad_oe, 9'h0);
    endtask : t_extest

    task automatic t_tms();
        master.bit_io(1'h1, 1'h0, q);
        master.bit_io(1'h0, 1'h0, q);
        master.bit_io(1'h0, 1'h0, q);
        repeat (4) @(posedge clk);
        #1;
        check("shift oe", tdo_oe, 9'h1);
        check("shift tdo", tdo, 9'h0);
        master.tms_reset();
        repeat (3) @(posedge clk);
        check("tms reset pads", pad_out, core_out);
        check("tms reset oe", pad_oe, 9'hff);
    endtask : t_tms

    task automatic t_trst();
        pins(8'h96, 8'hc3, 1'h0, 1'h1);
        load_ir(`BSDP_OP_EXTEST);
        master.scan(1'h0, 9, 9'h1ff, dout);
        check("ext drive", pad_oe, 9'hff);
        master.trst_pulse();
        check("trst pads", pad_out, core_out);
        check("trst oe", pad_oe, 9'h0);
        master.tms_reset();
    endtask : t_trst

    task automatic t_fifo();
        logic [4:0] walk = 5'h0d;
        int         n = 0;
        load_ir(`BSDP_OP_SAMPLE);
        for (int i = 0; i < 10; i++) begin
            pins(i[7:0], 8'hc3, 1'h1, 1'h0);
            for (int k = 0; k < 5; k++)
                master.bit_io(walk[k], 1'h0, q);
        end
        check("fifo full", snap_space, 9'h0);
        @(posedge clk);
        #1;
        snap_ready = 1'h1;
        repeat (40) begin
            @(negedge clk);
            if (snap_valid === 1'h1) begin
                check("snap word", snap_data, {1'h1, n[7:0]});
                n++;
            end
        end
        check("snap count", n[8:0], 9'h9);
    endtask : t_fifo

    // watchdog: the run needs well under half of this span
    initial begin
        #2000000;
        errors++;
        end_sim();
    end

    initial begin
        clk = 1'h0;
        nrst = 1'h0;
        pad_in = 8'h00;
        core_out = 8'hc3;
        core_oe = 1'h0;
        snap_ready = 1'h1;
        errors = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_bypass();
        t_sample();
        t_extest();
        t_tms();
        t_trst();
        t_fifo();
        end_sim();
    end
endmodule : test_bsdp_top
